// [rtl/ldh_host.v]
// Two-wire host that writes and reads LED driver registers on APB orders
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "ldh_defs.vh"
module ldh_host #(
   parameter QUARTER = `LDH_QUARTER_MIN
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         scl_out,
   output reg         scl_oe,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe,
   output reg  [1:0]  low_address_strap,
   output reg  [1:0]  high_address_strap
);
   localparam [6:0] ST_IDLE  = 7'b0000001;
   localparam [6:0] ST_START = 7'b0000010;
   localparam [6:0] ST_BIT   = 7'b0000100;
   localparam [6:0] ST_ACK   = 7'b0001000;
   localparam [6:0] ST_RSTRT = 7'b0010000;
   localparam [6:0] ST_STOP  = 7'b0100000;
   localparam [6:0] ST_RBIT  = 7'b1000000;

   reg  [6:0]  state_reg;
   reg  [7:0]  reg_ptr_reg;
   reg  [7:0]  wdata_reg;
   reg  [7:0]  rdata_reg;
   reg  [7:0]  shift_reg;
   reg  [2:0]  bit_reg;
   reg  [1:0]  phase_reg;
   reg  [1:0]  byte_reg;
   reg  [15:0] div_reg;
   reg  [15:0] cnt_reg;
   reg         read_reg;
   reg         nack_reg;
   reg         done_reg;
   reg         sda_s1_reg;
   reg         sda_s2_reg;
   reg         sda_s3_reg;
   reg         sda_reg;
   wire        tick;
   wire [6:0]  dev_addr;
   wire        apb_wr;
   wire        apb_rd;
   wire        busy;

   assign busy     = (state_reg != ST_IDLE);
   assign tick     = (cnt_reg == 16'h0000);
   assign dev_addr = {`LDH_ADDR_FIXED, high_address_strap, low_address_strap};
   assign apb_wr   = psel & penable & pwrite & pready;
   assign apb_rd   = psel & penable & ~pwrite & pready;

   // SDA input filter: change counts when second and third stages agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_s3_reg <= 1'b1;
         sda_reg    <= 1'b1;
      end else begin
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_s3_reg <= sda_s2_reg;
         if (sda_s2_reg == sda_s3_reg) begin
            sda_reg <= sda_s3_reg;
         end
      end
   end

   // APB slave: one wait state, so pready rises in the second access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (psel & penable & ~pready) begin
            case (paddr)
               `LDH_CTRL_OFS:  prdata <= {20'h00000, high_address_strap,
                                          low_address_strap, 6'h00, read_reg, 1'b0};
               `LDH_DATA_OFS:  prdata <= {16'h0000, reg_ptr_reg, wdata_reg};
               `LDH_STAT_OFS:  prdata <= {29'h00000000, done_reg, nack_reg, busy};
               `LDH_RDATA_OFS: prdata <= {24'h000000, rdata_reg};
               `LDH_DIV_OFS:   prdata <= {16'h0000, div_reg};
               default: begin
                  prdata  <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // Byte sequencer and bus clock generator
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg          <= ST_IDLE;
         reg_ptr_reg        <= 8'h00;
         wdata_reg          <= 8'h00;
         rdata_reg          <= 8'h00;
         shift_reg          <= 8'h00;
         bit_reg            <= 3'h0;
         phase_reg          <= 2'h0;
         byte_reg           <= 2'h0;
         div_reg            <= QUARTER[15:0];
         cnt_reg            <= 16'h0000;
         read_reg           <= 1'b0;
         nack_reg           <= 1'b0;
         done_reg           <= 1'b0;
         scl_out            <= 1'b1;
         scl_oe             <= 1'b1;
         sda_out            <= 1'b1;
         sda_oe             <= 1'b0;
         low_address_strap  <= 2'b00;
         high_address_strap <= 2'b00;
      end else begin
         if (apb_wr && paddr == `LDH_DATA_OFS) begin
            reg_ptr_reg <= pwdata[15:8];
            wdata_reg   <= pwdata[7:0];
         end
         // Divider never below the 1 MHz limit
         if (apb_wr && paddr == `LDH_DIV_OFS) begin
            div_reg <= (pwdata[15:0] < QUARTER[15:0]) ? QUARTER[15:0] : pwdata[15:0];
         end
         if (apb_wr && paddr == `LDH_STAT_OFS) begin
            if (pwdata[`LDH_STAT_NACK]) nack_reg <= 1'b0;
            if (pwdata[`LDH_STAT_DONE]) done_reg <= 1'b0;
         end
         cnt_reg <= tick ? div_reg - 16'h0001 : cnt_reg - 16'h0001;
         case (state_reg)
            ST_IDLE: begin
               sda_oe  <= 1'b0;
               scl_out <= 1'b1;
               cnt_reg <= div_reg;
               if (apb_wr && paddr == `LDH_CTRL_OFS && pwdata[`LDH_CTRL_START]) begin
                  read_reg           <= pwdata[`LDH_CTRL_READ];
                  low_address_strap  <= pwdata[`LDH_CTRL_STRAP_LO+1:`LDH_CTRL_STRAP_LO];
                  high_address_strap <= pwdata[`LDH_CTRL_STRAP_HI+1:`LDH_CTRL_STRAP_HI];
                  nack_reg           <= 1'b0;
                  done_reg           <= 1'b0;
                  byte_reg           <= 2'h0;
                  phase_reg          <= 2'h0;
                  state_reg          <= ST_START;
               end
            end
            ST_START: if (tick) begin
               // Phase 0: SDA low with SCL high; phase 1: SCL low
               phase_reg <= phase_reg + 2'h1;
               if (phase_reg == 2'h0) begin
                  sda_oe  <= 1'b1;
                  sda_out <= 1'b0;
               end else begin
                  scl_out   <= 1'b0;
                  phase_reg <= 2'h0;
                  bit_reg   <= 3'h7;
                  // Address with write direction opens both kinds
                  shift_reg <= (byte_reg == 2'h3) ? {dev_addr, 1'b1}
                                                  : {dev_addr, 1'b0};
                  state_reg <= ST_BIT;
               end
            end
            ST_BIT: if (tick) begin
               // Data changes only while SCL is low
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: begin
                     sda_oe  <= ~shift_reg[7];
                     sda_out <= 1'b0;
                  end
                  2'h1: scl_out <= 1'b1;
                  2'h2: scl_out <= 1'b1;
                  default: begin
                     scl_out   <= 1'b0;
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     bit_reg   <= bit_reg - 3'h1;
                     if (bit_reg == 3'h0) state_reg <= ST_ACK;
                  end
               endcase
            end
            ST_ACK: if (tick) begin
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: sda_oe <= 1'b0;
                  2'h1: scl_out <= 1'b1;
                  2'h2: begin
                     if (byte_reg != 2'h3 && sda_reg) begin
                        nack_reg <= 1'b1;
                     end
                  end
                  default: begin
                     scl_out   <= 1'b0;
                     sda_oe    <= 1'b0;
                     bit_reg   <= 3'h7;
                     byte_reg  <= byte_reg + 2'h1;
                     state_reg <= ST_BIT;
                     if (nack_reg || (byte_reg != 2'h3 && sda_reg)) begin
                        state_reg <= ST_STOP;
                     end else if (byte_reg == 2'h0) begin
                        shift_reg <= reg_ptr_reg;
                     end else if (byte_reg == 2'h1) begin
                        if (read_reg) state_reg <= ST_RSTRT;
                        else shift_reg <= wdata_reg;
                     end else if (byte_reg == 2'h2) begin
                        if (read_reg) state_reg <= ST_RBIT;
                        else state_reg <= ST_STOP;
                     end else begin
                        state_reg <= ST_STOP;
                     end
                  end
               endcase
            end
            ST_RSTRT: if (tick) begin
               // Release SDA, raise SCL, then fall SDA for a repeated start
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: sda_oe <= 1'b0;
                  2'h1: scl_out <= 1'b1;
                  2'h2: begin
                     sda_oe  <= 1'b1;
                     sda_out <= 1'b0;
                  end
                  default: begin
                     scl_out   <= 1'b0;
                     byte_reg  <= 2'h2;
                     shift_reg <= {dev_addr, 1'b1};
                     bit_reg   <= 3'h7;
                     state_reg <= ST_BIT;
                  end
               endcase
            end
            ST_RBIT: if (tick) begin
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: sda_oe <= 1'b0;
                  2'h1: scl_out <= 1'b1;
                  2'h2: shift_reg <= {shift_reg[6:0], sda_reg};
                  default: begin
                     scl_out <= 1'b0;
                     bit_reg <= bit_reg - 3'h1;
                     if (bit_reg == 3'h0) begin
                        rdata_reg <= shift_reg;
                        byte_reg  <= 2'h3;
                        state_reg <= ST_ACK;
                     end
                  end
               endcase
            end
            ST_STOP: if (tick) begin
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: begin
                     sda_oe  <= 1'b1;
                     sda_out <= 1'b0;
                  end
                  2'h1: scl_out <= 1'b1;
                  2'h2: sda_oe <= 1'b0;
                  default: begin
                     done_reg  <= 1'b1;
                     phase_reg <= 2'h0;
                     state_reg <= ST_IDLE;
                  end
               endcase
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule

// [pkg/ldh_defs.vh]
// Constants for the LED driver two-wire host controller
`ifndef LDH_DEFS_VH
`define LDH_DEFS_VH
// Own APB registers (byte addresses)
`define LDH_CTRL_OFS      12'h000
`define LDH_DATA_OFS      12'h004
`define LDH_STAT_OFS      12'h008
`define LDH_RDATA_OFS     12'h00c
`define LDH_DIV_OFS       12'h010
// Control register fields
`define LDH_CTRL_START    0
`define LDH_CTRL_READ     1
`define LDH_CTRL_STRAP_LO 8
`define LDH_CTRL_STRAP_HI 10
// Status register fields
`define LDH_STAT_BUSY     0
`define LDH_STAT_NACK     1
`define LDH_STAT_DONE     2
// Device register map
`define LDH_REG_CONFIG    8'h00
`define LDH_REG_GCC       8'h01
`define LDH_REG_SCALE     8'h02
`define LDH_REG_OPEN_EN   8'h14
`define LDH_REG_OPEN_ST   8'h15
`define LDH_REG_THERMAL   8'h18
`define LDH_REG_SPREAD    8'h19
`define LDH_REG_DC        8'h1a
`define LDH_REG_PHASE     8'h1d
`define LDH_REG_PWM       8'h1f
`define LDH_REG_PWM_LAST  8'h30
`define LDH_REG_BLINK_EN  8'h31
`define LDH_REG_BLINK_PER 8'h34
`define LDH_REG_BLINK_DUT 8'h35
`define LDH_REG_SCALE_UPD 8'h36
`define LDH_REG_UPDATE    8'h37
`define LDH_REG_RESET     8'h3f
// Configuration register bits
`define LDH_CFG_SHUTDOWN_RELEASE 0
`define LDH_CFG_SYNC_LO          1
`define LDH_CFG_PWM_RATE         4
`define LDH_CFG_CURRENT_EIGHTH   5
`define LDH_CFG_THRESHOLD        6
`define LDH_SYNC_MASTER          2'b10
`define LDH_SYNC_SLAVE           2'b11
// Fixed upper address bits A7:A5 (arbitrary value)
`define LDH_ADDR_FIXED    3'b101
// Timing: maximum bus clock 1 MHz, pclk 25 MHz
`define LDH_PCLK_HZ       25000000
`define LDH_SCL_MAX_HZ    1000000
`define LDH_QUARTER_MIN   ((`LDH_PCLK_HZ + 4*`LDH_SCL_MAX_HZ - 1) / (4*`LDH_SCL_MAX_HZ))
`endif

// [sim/ldh_dev_model.sv]
// Behavioural model of the LED driver register port on the two-wire bus
`timescale 1ns/1ns
`include "ldh_defs.vh"
module ldh_dev_model (
   input  wire       scl,
   input  wire       sda,
   input  wire [1:0] lo_strap,
   input  wire [1:0] hi_strap,
   output reg        pull
);
   reg [7:0] mem [0:63];
   reg [7:0] sh;
   reg [7:0] ptr;
   reg [3:0] bc;
   reg [2:0] st;
   integer   i;
   task restore;
      for (i = 0; i < 64; i = i + 1)
         mem[i] = i == 1 ? 8'h3f : i > 1 && i < 20 ? 8'hff : i == 20 ? 8'h03 : 8'h00;
   endtask
   initial begin
      {st, bc, pull, ptr, sh} = 0;
      restore;
   end
   always @(negedge sda) if (scl) {st, bc} = 7'h10;
   always @(posedge sda) if (scl) {st, pull} = 4'h0;
   always @(posedge scl) begin
      if (st != 3'd0 && bc < 4'd8) begin
         sh = {sh[6:0], sda};
         bc = bc + 4'd1;
      end else if (st == 3'd4 && bc == 4'd9 && sda)
         st = 3'd0;
   end
   // Bits and acknowledges change only while the bus clock is low
   always @(negedge scl) if (st != 3'd0) begin
      if (bc == 4'd9) begin
         bc = 4'd0;
         pull = 1'b0;
         if (st == 3'd4) begin
            sh = mem[ptr[5:0]];
            if (ptr > 8'h14 && ptr < 8'h18) mem[ptr[5:0]] = 8'h00;
         end
      end else if (bc == 4'd8) begin
         bc = 4'd9;
         pull = st != 3'd4;
         if (st == 3'd1) begin
            st = sh[0] ? 3'd4 : 3'd2;
            if (sh[7:1] != {`LDH_ADDR_FIXED, hi_strap, lo_strap}) {st, pull} = 4'h0;
         end else if (st == 3'd2) begin
            ptr = sh;
            st = 3'd3;
         end else if (st == 3'd3) begin
            if (ptr == 8'h3f) restore;
            else if (ptr < 8'h15 || ptr > 8'h17) mem[ptr[5:0]] = sh;
            ptr = ptr + 8'h01;
         end
      end
      if (st == 3'd4 && bc < 4'd8) pull = ~sh[7];
   end
endmodule

// [sim/ldh_host_chk.sv]
// Port assertions for the two-wire host controller
`timescale 1ns/1ns
module ldh_host_chk #(
   parameter QUARTER = 7
) (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        scl_out,
   input wire        scl_oe,
   input wire        sda_in,
   input wire        sda_out,
   input wire        sda_oe,
   input wire [1:0]  low_address_strap,
   input wire [1:0]  high_address_strap
);
   localparam int HOLD_MAX = 40;
   reg        scl_q;
   reg        sda_q;
   reg [15:0] run_cnt;
   reg [7:0]  hold_cnt;
   reg [3:0]  bit_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {scl_q, sda_q, run_cnt, hold_cnt, bit_cnt} <= {1'b1, 29'h0};
      end else begin
         scl_q <= scl_out;
         sda_q <= sda_oe;
         run_cnt <= (scl_out != scl_q) ? 16'h0001 : run_cnt + {15'h0, run_cnt != 16'hffff};
         hold_cnt <= (scl_out && sda_oe) ? hold_cnt + {7'h0, hold_cnt != 8'hff} : 8'h00;
         // Count clock pulses from each start; the ninth is the acknowledge
         if (scl_out && scl_q && sda_oe && !sda_q)
            bit_cnt <= 4'h0;
         else if (scl_out && !scl_q)
            bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      end
   end
   chk_ready_second: assert property (psel && penable && !pready && !$past(penable) |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_reset_state: assert property (disable iff (1'b0) !presetn |-> scl_out && !sda_oe && !pready)
      else $error("bad state in reset");
   chk_sda_open_drain: assert property (sda_oe |-> !sda_out && scl_oe)
      else $error("sda driven high");
   chk_bit_stable: assert property (scl_out && !scl_q |-> $stable(sda_oe) [*4])
      else $error("sda moved in clock high");
   chk_ack_release: assert property (scl_out && !scl_q && bit_cnt == 4'h8 |-> !sda_oe [*4])
      else $error("sda held in acknowledge");
   chk_clock_rate: assert property (scl_out != scl_q |-> run_cnt >= 2 * QUARTER - 2)
      else $error("bus clock phase too short");
   chk_idle_release: assert property (hold_cnt < HOLD_MAX)
      else $error("sda held low while clock high");
   cover property (pslverr);
   cover property (scl_out && !scl_q && bit_cnt == 4'h8 && sda_in);
   cover property (pready && !pwrite);
endmodule
bind ldh_host ldh_host_chk #(.QUARTER(QUARTER)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .low_address_strap(low_address_strap), .high_address_strap(high_address_strap));

// [sim/ldh_host_bench.sv]
// Self-checking bench: host controller against the LED driver port model
`timescale 1ns/1ns
`include "ldh_defs.vh"
module ldh_host_bench;
   reg         pclk, presetn, psel, penable, pwrite, perr;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, r, st;
   reg  [7:0]  a, d, q;
   reg  [3:0]  sp;
   reg  [1:0]  mis;
   wire [31:0] prdata;
   wire        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, dev_pull;
   wire [1:0]  lo_st, hi_st;
   wire        scl = scl_oe ? scl_out : 1'b1;
   wire        sda = (sda_oe ? sda_out : 1'b1) & !dev_pull; // Pull-up otherwise
   integer     errors, cmp_count, cyc, i;
   localparam [63:0] LST = 64'h0001_0213_1415_1f35;
   ldh_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .low_address_strap(lo_st), .high_address_strap(hi_st));
   ldh_dev_model dev_u (.scl(scl), .sda(sda), .lo_strap(lo_st ^ mis), .hi_strap(hi_st),
      .pull(dev_pull));
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 95000) begin
         errors = errors + 1;
         close_out;
      end
   end
   task close_out;
      begin
         $display("errors %0d compares %0d", errors, cmp_count);
         if (errors == 0 && cmp_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [32:0] got, input [32:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] wd);
      begin
         @(posedge pclk);
         {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) begin
            @(posedge pclk);
         end
         r = prdata;
         perr = pslverr;
         {psel, penable} <= 2'b00;
      end
   endtask
   task dev(input rd, input [7:0] ptr, input [7:0] dat);
      begin
         sp = $urandom;
         apb(1, `LDH_DATA_OFS, {16'h0000, ptr, dat});
         apb(1, `LDH_CTRL_OFS, {20'h00000, sp, 6'h00, rd, 1'b1});
         st = 0;
         while (st[`LDH_STAT_DONE] !== 1'b1) begin
            apb(0, `LDH_STAT_OFS, 0);
            st = r;
         end
         chk({hi_st, lo_st}, sp);
         apb(0, `LDH_RDATA_OFS, 0);
         q = r[7:0];
         apb(1, `LDH_STAT_OFS, 32'h6);
      end
   endtask
   function [7:0] dflt(input [7:0] ad);
      dflt = ad == 1 ? 8'h3f : ad > 1 && ad < 20 ? 8'hff : ad == 20 ? 8'h03 : 8'h00;
   endfunction
   initial begin
      {pclk, psel, penable, pwrite, paddr, pwdata, mis} = 0;
      presetn = 1'b1;
      {errors, cmp_count, cyc} = 0;
      i = $urandom(32'hcc291f4a);
      // Reset asserted off the clock edge so the design sees a clean falling edge
      #1 presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `LDH_STAT_OFS, 0);
      chk(r, 0);
      apb(0, 12'h020, 0);
      chk({perr, r}, 33'h100000000);
      apb(0, `LDH_DIV_OFS, 0);
      chk(r, `LDH_QUARTER_MIN);
      apb(1, `LDH_DIV_OFS, 7 + $urandom % 3);
      for (i = 0; i < 8; i = i + 1) begin
         a = LST[8 * i +: 8];
         dev(1, a, 0);
         chk(q, dflt(a));
      end
      // PWM bytes at both ends of the block, then every sync code in the configuration
      for (i = 0; i < 10; i = i + 1) begin
         a = i < 2 ? 8'h1f + 17 * i : i < 6 ? 8'h1f + $urandom % 18 : 8'h00;
         // Sync codes go slave first, then master, then the two idle codes
         d = i < 6 ? $urandom : ($urandom & 8'h71) | {5'h00, i[1:0] ^ 2'h1, 1'b0};
         dev(0, a, d);
         dev(1, a, 0);
         chk(q, d);
      end
      for (i = 0; i < 3; i = i + 1) begin
         a = i == 0 ? `LDH_REG_BLINK_PER : `LDH_REG_BLINK_DUT + i;
         dev(0, a, $urandom);
         chk(st[`LDH_STAT_NACK], 0);
      end
      d = $urandom;
      dev(0, `LDH_REG_RESET, d);
      apb(0, `LDH_DATA_OFS, 0);
      chk(r, {16'h0000, `LDH_REG_RESET, d});
      for (i = 0; i < 2; i = i + 1) begin
         dev(1, 8'h1f * i, 0);
         chk(q, 0);
      end
      mis <= 2'b01;
      dev(0, 8'h00, 8'h01);
      chk(st[`LDH_STAT_NACK], 1);
      mis <= 2'b00;
      apb(0, `LDH_STAT_OFS, 0);
      chk(r, 0);
      dev(1, 8'h00, 0);
      chk(q, 0);
      apb(0, `LDH_CTRL_OFS, 0);
      chk(r, {20'h00000, sp, 6'h00, 2'b10});
      close_out;
   end
endmodule
